// ---- hdl/afc_fan_ctrl.sv ----
// Automatic fan control, status flags, alert and over-temperature outputs.
//
// Overview of operation
// - Status-one read clears alarm and fault flags.
// - Alarm flag re-sets only after leaving alarm.
// - Fan fault flag sets on every tach failure.
// - Remote limit flags: set, read-clear, re-set.
// - Local limit flags in bits 6 and 7.
// - Remote over-temperature flag, read clears it.
// - Power-up diode error flag, reads never clear it.
// - Local over-temperature flag in status two.
// - External low on overtemp pin sets flag.
// - Over-temperature drives alert and overtemp low.
// - Status read releases the alert output.
// - Overtemp stays low until 5 below limit.
// - Alert re-arms only 5 below limit.
// - Auto and software duty modes.
// - Fan off below turn-on, then minimum duty.
// - Spin-up at full duty before computed duty.
// - Three-bit spin-up time select, 200ms-8s.
// - Duty rises along range, full at end.
// - Fan stays on until 5 below turn-on.
// - Turn-on in 4 degree steps, shifts curve.
// - Config bit 7 selects auto, default on.
// - Channel select: remote alone, local alone or larger duty.
// - Duty codes of fifteen steps, 15 full.
// - Four-bit minimum duty, default code 5.
// - Turn-on bits 7:3, range bits 2:0.
// - Cleared enable masks flags and alert.
`timescale 1ns/1ps
`include "afc_consts.svh"

module afc_fan_ctrl #(
    parameter int unsigned MS_CYCLES = `AFC_MS_CYCLES
) (
    // Clock and reset
    input  wire  logic                 clk_sys,
    input  wire  logic                 rst_n,
    // Register port of the serial bus engine
    input  wire  logic [7:0]           reg_addr,
    input  wire  logic                 reg_wr,
    input  wire  logic [7:0]           reg_wdata,
    input  wire  logic                 reg_rd,
    output logic       [7:0]           reg_rdata,
    // Temperature results
    input  wire  afc_pkg::afc_temp_t   loc_temp,
    input  wire  afc_pkg::afc_temp_t   rem_temp,
    // Fan and diode status
    input  wire  logic                 alarm_speed,
    input  wire  logic                 tach_fail,
    input  wire  logic                 diode_fault,
    // Pins
    output logic                       pwm_out,
    output logic                       alert_n,
    input  wire  logic                 overtemp_n_i,
    output logic                       overtemp_n_o,
    output logic                       overtemp_n_oe
);
    // Channel 0 is local, channel 1 is remote.
    logic [7:0] cfg1_r;
    logic [7:0] cfg2_r;
    logic [7:0] traits_r;
    logic [7:0] speed_r;
    logic [7:0] tparam_r [2];
    logic [7:0] lim_hi_r [2];
    logic [7:0] lim_lo_r [2];
    logic [7:0] lim_th_r [2];
    logic [7:0] sts1_r;
    logic [7:0] sts2_r;
    logic [7:0] sts1_set;
    logic [7:0] sts2_set;
    logic       rd_sts1;
    logic       rd_sts2;
    afc_pkg::afc_temp_t ch_temp [2];
    logic       act_r    [2];
    logic       on_r     [2];
    logic [3:0] duty_r   [2];
    logic       hi_ev    [2];
    logic       lo_ev    [2];
    logic       th_ev    [2];
    logic       alarm_q_r;
    logic       ext_low_q_r;
    logic       ext_low;
    logic       strap_done_r;
    logic [3:0] demand;
    logic [3:0] duty_out_r;
    afc_pkg::afc_fan_state_t fan_st_r;
    afc_pkg::afc_fan_state_t fan_st_nxt;
    logic [14:0] pre_cnt_r;
    logic [12:0] ms_cnt_r;
    logic        ms_tick;
    logic        spin_done;
    logic [16:0] slot_cnt_r;
    logic [3:0]  phase_r;
    logic [7:0]  rdata_nxt;

    function automatic logic [3:0] chan_duty(input logic [7:0] temp,
                                             input logic [7:0] tp,
                                             input logic [3:0] min_code,
                                             input logic       on);
        logic signed [9:0] diff;
        logic        [9:0] steps;
        logic        [2:0] rng;
        logic        [9:0] sum;
        diff  = $signed({{2{temp[7]}}, temp}) -
                $signed({3'h0, tp[7:3], 2'h0});
        rng   = (tp[2:0] > 3'h4) ? 3'h4 : tp[2:0];
        steps = 10'(unsigned'(diff) << 1) >> rng;
        sum   = {6'h0, min_code} + steps;
        if (!on) begin
            chan_duty = 4'h0;
        end else if (diff <= 10'sd0) begin
            chan_duty = min_code;
        end else if (sum >= {6'h0, `AFC_DUTY_FULL}) begin
            chan_duty = `AFC_DUTY_FULL;
        end else begin
            chan_duty = sum[3:0];
        end
    endfunction

    function automatic logic [12:0] spin_ms(input logic [2:0] code);
        unique case (code)
            3'h0: spin_ms = 13'(`AFC_SPIN_MS_0);
            3'h1: spin_ms = 13'(`AFC_SPIN_MS_1);
            3'h2: spin_ms = 13'(`AFC_SPIN_MS_2);
            3'h3: spin_ms = 13'(`AFC_SPIN_MS_3);
            3'h4: spin_ms = 13'(`AFC_SPIN_MS_4);
            3'h5: spin_ms = 13'(`AFC_SPIN_MS_5);
            3'h6: spin_ms = 13'(`AFC_SPIN_MS_6);
            3'h7: spin_ms = 13'(`AFC_SPIN_MS_7);
        endcase
    endfunction

    function automatic logic [16:0] slot_len(input logic [2:0] code);
        unique case (code)
            3'h0: slot_len = 17'(MS_CYCLES * 10000 / (`AFC_PWM_DHZ_0 * `AFC_PWM_SLOTS));
            3'h1: slot_len = 17'(MS_CYCLES * 10000 / (`AFC_PWM_DHZ_1 * `AFC_PWM_SLOTS));
            3'h2: slot_len = 17'(MS_CYCLES * 10000 / (`AFC_PWM_DHZ_2 * `AFC_PWM_SLOTS));
            3'h3: slot_len = 17'(MS_CYCLES * 10000 / (`AFC_PWM_DHZ_3 * `AFC_PWM_SLOTS));
            3'h4: slot_len = 17'(MS_CYCLES * 10000 / (`AFC_PWM_DHZ_4 * `AFC_PWM_SLOTS));
            3'h5: slot_len = 17'(MS_CYCLES * 10000 / (`AFC_PWM_DHZ_5 * `AFC_PWM_SLOTS));
            3'h6: slot_len = 17'(MS_CYCLES * 10000 / (`AFC_PWM_DHZ_6 * `AFC_PWM_SLOTS));
            3'h7: slot_len = 17'(MS_CYCLES * 10000 / (`AFC_PWM_DHZ_7 * `AFC_PWM_SLOTS));
        endcase
    endfunction

    assign ch_temp[0] = loc_temp;
    assign ch_temp[1] = rem_temp;
    assign rd_sts1    = reg_rd && (reg_addr == `AFC_OFF_STS1);
    assign rd_sts2    = reg_rd && (reg_addr == `AFC_OFF_STS2);

    // Register writes; status registers ignore writes.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg1_r      <= `AFC_RST_CFG1;
            cfg2_r      <= `AFC_RST_CFG2;
            traits_r    <= `AFC_RST_TRAITS;
            speed_r     <= `AFC_RST_SPEED;
            tparam_r[0] <= `AFC_RST_LOC_TP;
            tparam_r[1] <= `AFC_RST_REM_TP;
            lim_hi_r[0] <= `AFC_RST_HI;
            lim_hi_r[1] <= `AFC_RST_HI;
            lim_lo_r[0] <= `AFC_RST_LO;
            lim_lo_r[1] <= `AFC_RST_LO;
            lim_th_r[0] <= `AFC_RST_TH;
            lim_th_r[1] <= `AFC_RST_TH;
        end else if (reg_wr) begin
            case (reg_addr)
                `AFC_OFF_CFG1:   cfg1_r      <= reg_wdata;
                `AFC_OFF_CFG2:   cfg2_r      <= reg_wdata;
                `AFC_OFF_TRAITS: traits_r    <= reg_wdata;
                `AFC_OFF_SPEED:  speed_r     <= {4'h0, reg_wdata[3:0]};
                `AFC_OFF_LOC_TP: tparam_r[0] <= reg_wdata;
                `AFC_OFF_REM_TP: tparam_r[1] <= reg_wdata;
                `AFC_OFF_LOC_HI: lim_hi_r[0] <= reg_wdata;
                `AFC_OFF_REM_HI: lim_hi_r[1] <= reg_wdata;
                `AFC_OFF_LOC_LO: lim_lo_r[0] <= reg_wdata;
                `AFC_OFF_REM_LO: lim_lo_r[1] <= reg_wdata;
                `AFC_OFF_LOC_TH: lim_th_r[0] <= reg_wdata;
                `AFC_OFF_REM_TH: lim_th_r[1] <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Per-channel limit checks, over-temperature state and auto duty.
    for (genvar c = 0; c < 2; c++) begin : g_chan
        logic signed [7:0] t;
        logic signed [8:0] th_rel;
        assign t      = $signed(ch_temp[c].value);
        assign th_rel = $signed({lim_th_r[c][7], lim_th_r[c]}) - 9'sd`AFC_HYST_C;
        // Limit events only on a fresh result, gated by the channel enable.
        assign hi_ev[c] = ch_temp[c].valid && cfg2_r[c] &&
                          (t > $signed(lim_hi_r[c]));
        assign lo_ev[c] = ch_temp[c].valid && cfg2_r[c] &&
                          (t < $signed(lim_lo_r[c]));
        // Flag only on entry, so the alert is not re-armed until the state drops.
        assign th_ev[c] = ch_temp[c].valid && cfg2_r[c] && !act_r[c] &&
                          (t > $signed(lim_th_r[c]));

        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                act_r[c] <= 1'b0;
            end else if (ch_temp[c].valid) begin
                if (t > $signed(lim_th_r[c])) begin
                    act_r[c] <= 1'b1;
                end else if ($signed({t[7], t}) <= th_rel) begin
                    act_r[c] <= 1'b0;
                end
            end
        end

        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                on_r[c]   <= 1'b0;
                duty_r[c] <= 4'h0;
            end else if (ch_temp[c].valid) begin
                if ($signed({t[7], t}) > $signed({1'b0, tparam_r[c][7:3], 3'h0}) >>> 1) begin
                    on_r[c]   <= 1'b1;
                    duty_r[c] <= chan_duty(ch_temp[c].value, tparam_r[c],
                                           speed_r[3:0], 1'b1);
                end else if ($signed({t[7], t}) <=
                             $signed({1'b0, tparam_r[c][7:3], 2'h0}) - 9'sd`AFC_HYST_C) begin
                    on_r[c]   <= 1'b0;
                    duty_r[c] <= 4'h0;
                end else begin
                    duty_r[c] <= chan_duty(ch_temp[c].value, tparam_r[c],
                                           speed_r[3:0], on_r[c]);
                end
            end
        end
    end

    // Status event collection.
    assign ext_low = !overtemp_n_i && !overtemp_n_oe;
    always_comb begin
        sts1_set                = 8'h00;
        sts1_set[`AFC_S1_ALARM]  = alarm_speed && !alarm_q_r;
        sts1_set[`AFC_S1_FAULT]  = tach_fail;
        sts1_set[`AFC_S1_REM_HI] = hi_ev[1];
        sts1_set[`AFC_S1_REM_LO] = lo_ev[1];
        sts1_set[`AFC_S1_REM_TH] = th_ev[1];
        sts1_set[`AFC_S1_DIODE]  = !strap_done_r && diode_fault;
        sts1_set[`AFC_S1_LOC_HI] = hi_ev[0];
        sts1_set[`AFC_S1_LOC_LO] = lo_ev[0];
        sts2_set                = 8'h00;
        sts2_set[`AFC_S2_LOC_TH] = th_ev[0];
        sts2_set[`AFC_S2_PIN]    = ext_low && !ext_low_q_r;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            alarm_q_r    <= 1'b0;
            ext_low_q_r  <= 1'b0;
            strap_done_r <= 1'b0;
        end else begin
            alarm_q_r    <= alarm_speed;
            ext_low_q_r  <= ext_low;
            strap_done_r <= 1'b1;
        end
    end

    // A set in the same cycle as the clearing read wins.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sts1_r <= 8'h00;
        end else if (rd_sts1) begin
            sts1_r <= (sts1_r & (8'h01 << `AFC_S1_DIODE)) | sts1_set;
        end else begin
            sts1_r <= sts1_r | sts1_set;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sts2_r <= 8'h00;
        end else if (rd_sts2) begin
            sts2_r <= sts2_set;
        end else begin
            sts2_r <= sts2_r | sts2_set;
        end
    end

    // The diode flag cannot be cleared by a read, so it is kept off the alert to avoid a stuck line.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            alert_n       <= 1'b1;
            overtemp_n_oe <= 1'b0;
        end else begin
            alert_n       <= !(|(sts1_r & ~(8'h01 << `AFC_S1_DIODE)) ||
                               sts2_r[`AFC_S2_LOC_TH]);
            overtemp_n_oe <= act_r[0] || act_r[1];
        end
    end
    assign overtemp_n_o = 1'b0;

    // Duty demand: auto selection, or the software nibble when auto is off.
    always_comb begin
        demand = speed_r[3:0];
        if (cfg1_r[`AFC_CFG1_AUTO]) begin
            unique case ({cfg1_r[`AFC_CFG1_SEL_HI], cfg1_r[`AFC_CFG1_SEL_LO]})
                2'b00: demand = duty_r[1];
                2'b01: demand = duty_r[0];
                2'b10,
                2'b11: demand = (duty_r[0] > duty_r[1]) ? duty_r[0] : duty_r[1];
            endcase
            if (ext_low) begin
                demand = `AFC_DUTY_FULL;
            end
        end
    end

    // Millisecond tick for spin-up timing.
    assign ms_tick   = (pre_cnt_r == 15'(MS_CYCLES - 1));
    assign spin_done = ms_tick && (ms_cnt_r == spin_ms(traits_r[2:0]) - 13'h1);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt_r <= 15'h0000;
            ms_cnt_r  <= 13'h0000;
        end else if (fan_st_r != afc_pkg::AFC_FAN_SPIN) begin
            pre_cnt_r <= 15'h0000;
            ms_cnt_r  <= 13'h0000;
        end else if (ms_tick) begin
            pre_cnt_r <= 15'h0000;
            ms_cnt_r  <= ms_cnt_r + 13'h0001;
        end else begin
            pre_cnt_r <= pre_cnt_r + 15'h0001;
        end
    end

    always_comb begin
        fan_st_nxt = fan_st_r;
        unique case (fan_st_r)
            afc_pkg::AFC_FAN_OFF: begin
                if (demand != 4'h0) begin
                    fan_st_nxt = afc_pkg::AFC_FAN_SPIN;
                end
            end
            afc_pkg::AFC_FAN_SPIN: begin
                if (demand == 4'h0) begin
                    fan_st_nxt = afc_pkg::AFC_FAN_OFF;
                end else if (spin_done) begin
                    fan_st_nxt = afc_pkg::AFC_FAN_RUN;
                end
            end
            afc_pkg::AFC_FAN_RUN: begin
                if (demand == 4'h0) begin
                    fan_st_nxt = afc_pkg::AFC_FAN_OFF;
                end
            end
            default: fan_st_nxt = afc_pkg::AFC_FAN_OFF;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fan_st_r   <= afc_pkg::AFC_FAN_OFF;
            duty_out_r <= 4'h0;
        end else begin
            fan_st_r <= fan_st_nxt;
            if (fan_st_nxt == afc_pkg::AFC_FAN_SPIN) begin
                duty_out_r <= `AFC_DUTY_FULL;
            end else if (fan_st_nxt == afc_pkg::AFC_FAN_RUN) begin
                duty_out_r <= demand;
            end else begin
                duty_out_r <= 4'h0;
            end
        end
    end

    // PWM: fifteen slots a period, so code 15 holds the output high.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            slot_cnt_r <= 17'h00000;
            phase_r    <= 4'h0;
            pwm_out    <= 1'b0;
        end else begin
            if (slot_cnt_r >= slot_len(traits_r[5:3]) - 17'h00001) begin
                slot_cnt_r <= 17'h00000;
                phase_r    <= (phase_r == 4'(`AFC_PWM_SLOTS - 1)) ? 4'h0 : phase_r + 4'h1;
            end else begin
                slot_cnt_r <= slot_cnt_r + 17'h00001;
            end
            pwm_out <= (phase_r < duty_out_r);
        end
    end

    // Register reads, one cycle after the strobe; unmapped offsets read zero.
    always_comb begin
        unique case (reg_addr)
            `AFC_OFF_CFG1:   rdata_nxt = cfg1_r;
            `AFC_OFF_CFG2:   rdata_nxt = cfg2_r;
            `AFC_OFF_STS1:   rdata_nxt = sts1_r;
            `AFC_OFF_STS2:   rdata_nxt = sts2_r;
            `AFC_OFF_TRAITS: rdata_nxt = traits_r;
            `AFC_OFF_SPEED:  rdata_nxt = speed_r;
            `AFC_OFF_LOC_TP: rdata_nxt = tparam_r[0];
            `AFC_OFF_REM_TP: rdata_nxt = tparam_r[1];
            `AFC_OFF_LOC_HI: rdata_nxt = lim_hi_r[0];
            `AFC_OFF_REM_HI: rdata_nxt = lim_hi_r[1];
            `AFC_OFF_LOC_LO: rdata_nxt = lim_lo_r[0];
            `AFC_OFF_REM_LO: rdata_nxt = lim_lo_r[1];
            `AFC_OFF_LOC_TH: rdata_nxt = lim_th_r[0];
            `AFC_OFF_REM_TH: rdata_nxt = lim_th_r[1];
            default:         rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end
    end
endmodule

// ---- shared/afc_consts.svh ----
// Offsets, field positions, reset values and timing figures of the fan controller.
`ifndef AFC_CONSTS_SVH
`define AFC_CONSTS_SVH
`define AFC_CLK_HZ        20000000
`define AFC_OFF_CFG1      8'h00
`define AFC_OFF_CFG2      8'h01
`define AFC_OFF_STS1      8'h02
`define AFC_OFF_STS2      8'h03
`define AFC_OFF_LOC_HI    8'h14
`define AFC_OFF_LOC_LO    8'h15
`define AFC_OFF_LOC_TH    8'h16
`define AFC_OFF_REM_HI    8'h17
`define AFC_OFF_REM_LO    8'h18
`define AFC_OFF_REM_TH    8'h19
`define AFC_OFF_TRAITS    8'h20
`define AFC_OFF_SPEED     8'h22
`define AFC_OFF_LOC_TP    8'h24
`define AFC_OFF_REM_TP    8'h25
`define AFC_RST_CFG1      8'h80
`define AFC_RST_CFG2      8'h03
`define AFC_RST_TRAITS    8'h1d
`define AFC_RST_SPEED     8'h05
`define AFC_RST_LOC_TP    8'h42
`define AFC_RST_REM_TP    8'h62
`define AFC_RST_HI        8'h46
`define AFC_RST_LO        8'h00
`define AFC_RST_TH        8'h50
`define AFC_CFG1_AUTO     7
`define AFC_CFG1_SEL_HI   6
`define AFC_CFG1_SEL_LO   5
`define AFC_S1_ALARM      0
`define AFC_S1_FAULT      1
`define AFC_S1_REM_HI     2
`define AFC_S1_REM_LO     3
`define AFC_S1_REM_TH     4
`define AFC_S1_DIODE      5
`define AFC_S1_LOC_HI     6
`define AFC_S1_LOC_LO     7
`define AFC_S2_LOC_TH     6
`define AFC_S2_PIN        7
`define AFC_HYST_C        5
`define AFC_TMIN_STEP_SH  2
`define AFC_DUTY_FULL     4'hf
`define AFC_PWM_SLOTS     15
`define AFC_MS_CYCLES     (`AFC_CLK_HZ / 1000)
`define AFC_SPIN_MS_0     200
`define AFC_SPIN_MS_1     400
`define AFC_SPIN_MS_2     600
`define AFC_SPIN_MS_3     800
`define AFC_SPIN_MS_4     1000
`define AFC_SPIN_MS_5     2000
`define AFC_SPIN_MS_6     4000
`define AFC_SPIN_MS_7     8000
`define AFC_PWM_DHZ_0     117
`define AFC_PWM_DHZ_1     156
`define AFC_PWM_DHZ_2     234
`define AFC_PWM_DHZ_3     312
`define AFC_PWM_DHZ_4     375
`define AFC_PWM_DHZ_5     469
`define AFC_PWM_DHZ_6     625
`define AFC_PWM_DHZ_7     935
`endif

// ---- shared/afc_pkg.sv ----
// Types shared by the fan controller and its bench.
package afc_pkg;
    typedef struct packed {
        logic       valid;
        logic [7:0] value;
    } afc_temp_t;
    typedef enum logic [2:0] {
        AFC_FAN_OFF  = 3'b001,
        AFC_FAN_SPIN = 3'b010,
        AFC_FAN_RUN  = 3'b100
    } afc_fan_state_t;
endpackage

// ---- testbench/afc_fan_chk.sv ----
// Port checker for the fan controller.
`timescale 1ns/1ps
`include "afc_consts.svh"
module afc_fan_chk (
    // Clock and reset
    input wire logic               clk_sys,
    input wire logic               rst_n,
    // Register port and inputs
    input wire logic [7:0]         reg_addr,
    input wire logic               reg_wr,
    input wire logic [7:0]         reg_wdata,
    input wire logic               reg_rd,
    input wire logic [7:0]         reg_rdata,
    input wire afc_pkg::afc_temp_t loc_temp,
    input wire afc_pkg::afc_temp_t rem_temp,
    input wire logic               alarm_speed,
    input wire logic               tach_fail,
    // Pins
    input wire logic               pwm_out,
    input wire logic               alert_n,
    input wire logic               overtemp_n_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [7:0] rth_r;
    logic [7:0] lth_r;
    logic [6:0] low_r;
    // The over-temperature limits are shadowed here because the checker cannot see the registers.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rth_r <= `AFC_RST_TH;
            lth_r <= `AFC_RST_TH;
        end else begin
            if (reg_wr && reg_addr == `AFC_OFF_REM_TH) rth_r <= reg_wdata;
            if (reg_wr && reg_addr == `AFC_OFF_LOC_TH) lth_r <= reg_wdata;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) low_r <= 7'h00;
        else low_r <= pwm_out ? 7'h00 : (low_r[6] ? low_r : low_r + 7'h01);
    end
    wire hot = (rem_temp.valid && $signed(rem_temp.value) > $signed(rth_r))
            || (loc_temp.valid && $signed(loc_temp.value) > $signed(lth_r));
    wire cool = (rem_temp.valid && int'($signed(rem_temp.value)) <= int'($signed(rth_r)) - 5)
             || (loc_temp.valid && int'($signed(loc_temp.value)) <= int'($signed(lth_r)) - 5);
    wire rd_sts = reg_rd && (reg_addr == `AFC_OFF_STS1 || reg_addr == `AFC_OFF_STS2);
    sequence s_calm;
        !loc_temp.valid && !rem_temp.valid && !tach_fail && !$rose(alarm_speed);
    endsequence
    sequence s_rdq;
        reg_rd && reg_addr == `AFC_OFF_STS1 ##0 s_calm;
    endsequence
    sequence s_full;
        pwm_out [*8];
    endsequence
    property p_rd_clr; s_rdq ##1 s_calm ##1 s_rdq |=> (reg_rdata & 8'hdf) == 8'h00; endproperty
    property p_oe_on; rem_temp.valid && $signed(rem_temp.value) > $signed(rth_r)
        |-> ##2 overtemp_n_oe; endproperty
    property p_oe_off; $fell(overtemp_n_oe) |-> $past(cool, 2); endproperty
    property p_oe_cause; $rose(overtemp_n_oe) |-> $past(hot, 2); endproperty
    property p_oe_alert; $rose(overtemp_n_oe) |-> !alert_n; endproperty
    property p_alert_rel; $rose(alert_n) |-> $past(rd_sts, 2); endproperty
    property p_spin; $rose(pwm_out) && low_r[6] |-> s_full; endproperty
    property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
    a_rd_clr: assert property (p_rd_clr) else $error("flags not cleared by read");
    a_oe_on: assert property (p_oe_on) else $error("overtemp not driven");
    a_oe_off: assert property (p_oe_off) else $error("overtemp released early");
    a_oe_cause: assert property (p_oe_cause) else $error("overtemp without cause");
    a_oe_alert: assert property (p_oe_alert) else $error("alert not low");
    a_alert_rel: assert property (p_alert_rel) else $error("alert rose unread");
    a_spin: assert property (p_spin) else $error("spin-up not at full duty");
    a_hold: assert property (p_hold) else $error("read data changed");
endmodule

// ---- testbench/afc_fan_model.sv ----
// Fan model: a jammed rotor reports one tach failure and alarm speed.
`timescale 1ns/1ps
module afc_fan_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Drive and jam command
    input wire logic pwm_out,
    input wire logic jam,
    // Status to the controller
    output logic     tach_fail,
    output logic     alarm_speed
);
    logic jam_r;
    // Only a driven fan can be seen to fail, so the pulse waits for a high PWM cycle.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            jam_r       <= 1'b0;
            tach_fail   <= 1'b0;
            alarm_speed <= 1'b0;
        end else begin
            jam_r       <= jam && (jam_r || pwm_out);
            tach_fail   <= jam && pwm_out && !jam_r;
            alarm_speed <= jam;
        end
    end
endmodule

// ---- testbench/test_afc_fan_ctrl.sv ----
// Self-checking bench for the fan controller.
`timescale 1ns/1ps
`include "afc_consts.svh"
module test_afc_fan_ctrl;
    logic clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, jam = 1'b0, ext = 1'b0;
    logic dio = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    afc_pkg::afc_temp_t loc_temp = '0, rem_temp = '0;
    logic pwm_out, alert_n, ot_o, ot_oe, tach_fail, alarm_speed;
    int bad_count = 0, tests_run = 0, cyc = 0;
    wire ot_pin = ot_oe ? ot_o : !ext;
    always #25 clk_sys = ~clk_sys;
    afc_fan_ctrl #(.MS_CYCLES(4)) i_afc_fan_ctrl (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .loc_temp(loc_temp), .rem_temp(rem_temp),
        .alarm_speed(alarm_speed), .tach_fail(tach_fail), .diode_fault(dio),
        .pwm_out(pwm_out), .alert_n(alert_n), .overtemp_n_i(ot_pin),
        .overtemp_n_o(ot_o), .overtemp_n_oe(ot_oe));
    afc_fan_model i_afc_fan_model (.clk_sys(clk_sys), .rst_n(rst_n), .pwm_out(pwm_out),
        .jam(jam), .tach_fail(tach_fail), .alarm_speed(alarm_speed));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk_sys) reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk_sys) reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic tmp(input logic r, input logic [7:0] v);
        @(posedge clk_sys) if (r) rem_temp <= '{1'b1, v}; else loc_temp <= '{1'b1, v};
        @(posedge clk_sys) {rem_temp.valid, loc_temp.valid} <= 2'b00;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task automatic hi(input int len, output int n);
        n = 0;
        repeat (len) @(negedge clk_sys) n += pwm_out;
    endtask
    task automatic t_regs;
        logic [7:0] a [7] = '{8'h00, 8'h20, 8'h22, 8'h25, 8'h02, 8'h03, 8'h05};
        logic [7:0] e [7] = '{8'h80, 8'h1d, 8'h05, 8'h62, 8'h00, 8'h00, 8'h00};
        wr(`AFC_OFF_STS1, 8'hff);
        foreach (a[i]) rd(a[i], e[i]);
    endtask
    task automatic t_fan;
        int n;
        wr(`AFC_OFF_TRAITS, 8'h38);
        tmp(1'b1, 8'd49);
        n = 0;
        while (!pwm_out && n < 100) @(negedge clk_sys) n++;
        n = 0;
        while (pwm_out && n < 2000) @(negedge clk_sys) n++;
        chk(16'(n >= 785 && n <= 820), 16'd1);
        hi(300, n);
        chk(16'(n >= 90 && n <= 110), 16'd1);
        tmp(1'b1, 8'd78);
        hi(300, n);
        chk(16'(n), 16'd300);
        tmp(1'b1, 8'd44);
        hi(300, n);
        chk(16'(n > 0), 16'd1);
        tmp(1'b1, 8'd43);
        repeat (40) @(negedge clk_sys);
        hi(300, n);
        chk(16'(n), 16'd0);
    endtask
    task automatic t_overtemp_n;
        tmp(1'b1, 8'h60);
        chk({ot_oe, alert_n}, 2'b10);
        rd(`AFC_OFF_STS1, 8'h14);
        repeat (2) @(negedge clk_sys);
        chk({ot_oe, alert_n}, 2'b11);
        tmp(1'b1, 8'h4c);
        chk(ot_oe, 1'b1);
        rd(`AFC_OFF_STS1, 8'h04);
        tmp(1'b1, 8'h4b);
        chk(ot_oe, 1'b0);
        tmp(1'b1, 8'h60);
        rd(`AFC_OFF_STS1, 8'h14);
        tmp(1'b1, 8'h30);
        rd(`AFC_OFF_STS1, 8'h00);
    endtask
    task automatic t_fault;
        @(posedge clk_sys) jam <= 1'b1;
        repeat (40) @(posedge clk_sys);
        rd(`AFC_OFF_STS1, 8'h03);
        rd(`AFC_OFF_STS1, 8'h00);
        @(posedge clk_sys) jam <= 1'b0;
        repeat (4) @(posedge clk_sys);
        jam <= 1'b1;
        repeat (40) @(posedge clk_sys);
        rd(`AFC_OFF_STS1, 8'h03);
        @(posedge clk_sys) jam <= 1'b0;
    endtask
    task automatic t_pin;
        @(posedge clk_sys) ext <= 1'b1;
        repeat (3) @(posedge clk_sys);
        ext <= 1'b0;
        rd(`AFC_OFF_STS2, 8'h80);
        tmp(1'b0, 8'h60);
        rd(`AFC_OFF_STS2, 8'h40);
        rd(`AFC_OFF_STS2, 8'h00);
        rd(`AFC_OFF_STS1, 8'h40);
    endtask
    task automatic t_diode;
        @(posedge clk_sys) {rst_n, dio} <= 2'b01;
        @(posedge clk_sys) rst_n <= 1'b1;
        rd(`AFC_OFF_STS1, 8'h20);
        rd(`AFC_OFF_STS1, 8'h20);
    endtask
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs();
        t_fan();
        t_overtemp_n();
        t_fault();
        t_pin();
        t_diode();
        print_verdict();
    end
    // The whole sequence needs a few thousand cycles, so this ceiling only catches a hang.
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
endmodule
bind afc_fan_ctrl afc_fan_chk i_afc_fan_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .loc_temp(loc_temp), .rem_temp(rem_temp),
    .alarm_speed(alarm_speed), .tach_fail(tach_fail), .pwm_out(pwm_out),
    .alert_n(alert_n), .overtemp_n_oe(overtemp_n_oe));
